// *** logic/ocd_regs.svh ***
// constants of the command decoder: opcodes, parameter counts, reset values
// assumes inclusion by the decoder module only
`ifndef OCD_REGS_SVH
`define OCD_REGS_SVH

`define OCD_OP_MODE        8'h20
`define OCD_OP_COL_WIN     8'h21
`define OCD_OP_PAGE_WIN    8'h22
`define OCD_OP_CONTRAST    8'h81
`define OCD_OP_BRIGHT      8'h82
`define OCD_OP_PULSE_LUT   8'h91
`define OCD_OP_BANK_LO     8'h92
`define OCD_OP_BANK_HI     8'h93

`define OCD_NIB_COL_LO     4'h0
`define OCD_NIB_COL_HI     4'h1
`define OCD_LINE_PREFIX    2'h1

`define OCD_CNT_ONE        3'h1
`define OCD_CNT_TWO        3'h2
`define OCD_CNT_FOUR       3'h4

`define OCD_MODE_INVALID   2'h3
`define OCD_RST_MODE       2'h2
`define OCD_RST_COL_END    8'h83
`define OCD_RST_PAGE_END   3'h7
`define OCD_RST_LEVEL      8'h80
`define OCD_RST_PW_BANK0   6'h31
`define OCD_RST_PW_COLOR   6'h3F
`define OCD_PW_D_FIXED     7'h40

`endif

// *** logic/ocd_pkg.sv ***
// types of the command decoder: settings and internal state
// assumes nothing beyond the constants header
package ocd_pkg;

  typedef struct packed {
    logic [3:0]  col_lo;
    logic [3:0]  col_hi;
    logic [1:0]  addr_mode;
    logic [7:0]  col_start;
    logic [7:0]  col_end;
    logic [2:0]  page_start;
    logic [2:0]  page_end;
    logic [5:0]  start_line;
    logic [7:0]  contrast;
    logic [7:0]  brightness;
    logic [5:0]  pw_bank0;
    logic [5:0]  pw_a;
    logic [5:0]  pw_b;
    logic [5:0]  pw_c;
    logic [6:0]  pw_d;
    logic [31:0] bank_lo;
    logic [31:0] bank_hi;
  } ocd_cfg_t;

  typedef struct packed {
    ocd_cfg_t        cfg;
    logic [7:0]      op;
    logic [2:0]      left;
    logic [1:0]      idx;
    logic [3:0][7:0] prm;
    logic            busy;
  } ocd_state_t;

endpackage

// *** logic/ocd_decoder.sv ***
// command byte decoder: turns command and parameter bytes into settings
// assumes bytes already deframed, one byte per byte_valid cycle on sys_clk
`timescale 1ns/1ps
`include "ocd_regs.svh"

module ocd_decoder (
  input  wire logic          sys_clk,
  input  wire logic          resetn,
  input  wire logic          byte_valid,
  input  wire logic          byte_dc,
  input  wire logic [7:0]    byte_data,
  output ocd_pkg::ocd_cfg_t  cfg,
  output logic               busy
);

  ocd_pkg::ocd_state_t st;
  ocd_pkg::ocd_state_t next_st;
  logic                cmd;
  logic                last;

  // data bytes belong to the display memory path, not to this decoder
  assign cmd  = byte_valid & ~byte_dc;
  assign last = cmd & (st.left == `OCD_CNT_ONE);

  always_comb begin
    next_st = st;
    if (cmd) begin
      if (st.left != 3'h0) begin
        next_st.prm[st.idx] = byte_data;
        next_st.idx         = st.idx + 2'h1;
        next_st.left        = st.left - 3'h1;
        next_st.busy        = (st.left != `OCD_CNT_ONE);
        if (last) begin
          // apply all at once so a half-sent window never takes effect
          unique case (st.op)
            `OCD_OP_MODE: begin
              if (byte_data[1:0] != `OCD_MODE_INVALID) begin
                next_st.cfg.addr_mode = byte_data[1:0];
              end
            end
            `OCD_OP_COL_WIN: begin
              next_st.cfg.col_start = st.prm[0];
              next_st.cfg.col_end   = byte_data;
            end
            `OCD_OP_PAGE_WIN: begin
              next_st.cfg.page_start = st.prm[0][2:0];
              next_st.cfg.page_end   = byte_data[2:0];
            end
            `OCD_OP_CONTRAST: next_st.cfg.contrast = byte_data;
            `OCD_OP_BRIGHT:   next_st.cfg.brightness = byte_data;
            `OCD_OP_PULSE_LUT: begin
              next_st.cfg.pw_bank0 = st.prm[0][5:0];
              next_st.cfg.pw_a     = st.prm[1][5:0];
              next_st.cfg.pw_b     = st.prm[2][5:0];
              next_st.cfg.pw_c     = byte_data[5:0];
            end
            `OCD_OP_BANK_LO: begin
              next_st.cfg.bank_lo =
                {byte_data, st.prm[2], st.prm[1], st.prm[0]};
            end
            `OCD_OP_BANK_HI: begin
              next_st.cfg.bank_hi =
                {byte_data, st.prm[2], st.prm[1], st.prm[0]};
            end
            default: begin
            end
          endcase
        end
      end else begin
        next_st.op  = byte_data;
        next_st.idx = 2'h0;
        if (byte_data[7:4] == `OCD_NIB_COL_LO) begin
          next_st.cfg.col_lo = byte_data[3:0];
        end else if (byte_data[7:4] == `OCD_NIB_COL_HI) begin
          next_st.cfg.col_hi = byte_data[3:0];
        end else if (byte_data[7:6] == `OCD_LINE_PREFIX) begin
          next_st.cfg.start_line = byte_data[5:0];
        end else begin
          // opcodes outside this set are single bytes here; a limitation
          unique case (byte_data)
            `OCD_OP_MODE,
            `OCD_OP_CONTRAST,
            `OCD_OP_BRIGHT:    next_st.left = `OCD_CNT_ONE;
            `OCD_OP_COL_WIN,
            `OCD_OP_PAGE_WIN:  next_st.left = `OCD_CNT_TWO;
            `OCD_OP_PULSE_LUT,
            `OCD_OP_BANK_LO,
            `OCD_OP_BANK_HI:   next_st.left = `OCD_CNT_FOUR;
            default:           next_st.left = 3'h0;
          endcase
          next_st.busy = (next_st.left != 3'h0);
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st                <= '0;
      st.cfg.addr_mode  <= `OCD_RST_MODE;
      st.cfg.col_end    <= `OCD_RST_COL_END;
      st.cfg.page_end   <= `OCD_RST_PAGE_END;
      st.cfg.contrast   <= `OCD_RST_LEVEL;
      st.cfg.brightness <= `OCD_RST_LEVEL;
      st.cfg.pw_bank0   <= `OCD_RST_PW_BANK0;
      st.cfg.pw_a       <= `OCD_RST_PW_COLOR;
      st.cfg.pw_b       <= `OCD_RST_PW_COLOR;
      st.cfg.pw_c       <= `OCD_RST_PW_COLOR;
      st.cfg.pw_d       <= `OCD_PW_D_FIXED;
    end else begin
      st <= next_st;
    end
  end

  assign cfg  = st.cfg;
  assign busy = st.busy;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  a_data_byte_ignored: assert property (
    byte_valid && byte_dc |=> $stable(st))
    else $error("data byte changed decoder state");

  a_col_lo_load: assert property (
    cmd && st.left == 3'h0 && byte_data[7:4] == 4'h0
    |=> cfg.col_lo == $past(byte_data[3:0]))
    else $error("column low nibble not loaded");

  a_col_hi_load: assert property (
    cmd && st.left == 3'h0 && byte_data[7:4] == 4'h1
    |=> cfg.col_hi == $past(byte_data[3:0]) && $stable(cfg.col_lo))
    else $error("column high nibble not loaded");

  a_mode_invalid_kept: assert property (
    last && st.op == 8'h20 && byte_data[1:0] == 2'h3
    |=> $stable(cfg.addr_mode))
    else $error("invalid addressing mode accepted");

  a_col_window_set: assert property (
    last && st.op == `OCD_OP_COL_WIN
    |=> cfg.col_end == $past(byte_data)
        && cfg.col_start == $past(st.prm[0]))
    else $error("column window not applied");

  a_lut_apply: assert property (
    last && st.op == `OCD_OP_PULSE_LUT
    |=> cfg.pw_c == $past(byte_data[5:0])
        && cfg.pw_bank0 == $past(st.prm[0][5:0]))
    else $error("pulse width table not applied");

  a_page_window_set: assert property (
    last && st.op == 8'h22
    |=> cfg.page_end == $past(byte_data[2:0])
        && cfg.page_start == $past(st.prm[0][2:0]))
    else $error("page window not applied");

  a_start_line_load: assert property (
    cmd && st.left == 3'h0 && byte_data[7:6] == 2'h1
    |=> cfg.start_line == $past(byte_data[5:0]))
    else $error("start line not loaded");

  a_contrast_apply: assert property (
    last && st.op == 8'h81 |=> cfg.contrast == $past(byte_data) && !busy)
    else $error("contrast not applied");

  a_bright_apply: assert property (
    last && st.op == 8'h82 |=> cfg.brightness == $past(byte_data))
    else $error("brightness not applied");

  a_pw_d_fixed: assert property (
    $stable(cfg.pw_d) && cfg.pw_d == 7'h40)
    else $error("colour D pulse width moved");

  a_bank_hi_order: assert property (
    last && st.op == 8'h93
    |=> cfg.bank_hi[31:24] == $past(byte_data)
        && cfg.bank_hi[7:0] == $past(st.prm[0]))
    else $error("bank 17-32 colours misordered");

  a_lut_count: assert property (
    cmd && st.left == 3'h0 && byte_data == 8'h91
    |=> st.left == 3'h4 && busy)
    else $error("pulse table parameter count wrong");

  c_lut_done: cover property (last && st.op == 8'h91);
  c_bank_lo_done: cover property (last && st.op == 8'h92);
  c_data_midcmd: cover property (busy && byte_valid && byte_dc);
  c_mode_invalid: cover property (last && st.op == 8'h20
                                  && byte_data[1:0] == 2'h3);

endmodule

// *** tb/ocd_host.sv ***
// host model: offers command and data bytes, one per cycle
// assumes sys_clk from the bench; bytes change at the rising edge
`timescale 1ns/1ps
module ocd_host (
  input  wire logic       sys_clk,
  output logic            byte_valid,
  output logic            byte_dc,
  output logic [7:0]      byte_data
);
  initial begin
    byte_valid = 1'b0;
    byte_dc    = 1'b1;
    byte_data  = 8'h00;
  end
  // commands and parameters go with dc low
  task automatic put(input logic dc, input logic [7:0] d);
    @(posedge sys_clk);
    byte_valid <= 1'b1;
    byte_dc    <= dc;
    byte_data  <= d;
  endtask
  // idle: data inverted so a stale byte never looks fresh
  task automatic idle();
    @(posedge sys_clk);
    byte_valid <= 1'b0;
    byte_data  <= ~byte_data;
  endtask
endmodule

// *** tb/tb.sv ***
// bench: host model feeds the decoder, settings judged per command
// assumes ocd_host and ocd_decoder; assertions live in the design
`timescale 1ns/1ps
module tb;
  logic              sys_clk;
  logic              resetn;
  logic              byte_valid;
  logic              byte_dc;
  logic [7:0]        byte_data;
  ocd_pkg::ocd_cfg_t cfg;
  logic              busy;
  int                err_total;
  int                compares;
  int                cycles;
  ocd_host host (.sys_clk(sys_clk), .byte_valid(byte_valid),
    .byte_dc(byte_dc), .byte_data(byte_data));
  ocd_decoder uut (.sys_clk(sys_clk), .resetn(resetn),
    .byte_valid(byte_valid), .byte_dc(byte_dc), .byte_data(byte_data),
    .cfg(cfg), .busy(busy));
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      err_total++;
      $display("Error at %0t: got %h want %h", $time, s, e);
    end
  endtask
  task automatic results();
    $display("compares %0d errors %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_total++;
      results();
    end
  end
  task automatic op(input logic [7:0] b);
    host.put(1'b0, b);
  endtask
  // park the bus so the last byte lands
  task automatic fin();
    host.idle();
    #1;
  endtask
  task automatic five(input logic [7:0] a, b, c, d, e);
    op(a);
    op(b);
    op(c);
    op(d);
    op(e);
    fin();
  endtask
  task automatic t_reset();
    chk(busy, 1'b0);
    chk({cfg.col_lo, cfg.col_hi}, 8'h00);
    chk(cfg.addr_mode, 2'h2);
    chk({cfg.col_start, cfg.col_end}, 16'h0083);
    chk({cfg.page_start, cfg.page_end}, 6'h07);
    chk(cfg.start_line, 6'h00);
    chk({cfg.contrast, cfg.brightness}, 16'h8080);
    chk({cfg.pw_bank0, cfg.pw_a, cfg.pw_b, cfg.pw_c}, 24'hC7FFFF);
    chk(cfg.pw_d, 7'h40);
  endtask
  task automatic t_single();
    op(8'h0F);
    op(8'h1F);
    op(8'h7F);
    host.put(1'b1, 8'h05);
    fin();
    chk({cfg.col_lo, cfg.col_hi}, 8'hFF);
    chk(cfg.start_line, 6'h3F);
    op(8'h0A);
    op(8'h13);
    op(8'h45);
    fin();
    chk({cfg.col_lo, cfg.col_hi, cfg.start_line}, 14'h28C5);
  endtask
  task automatic t_mode();
    logic [1:0] exp;
    exp = 2'h2;
    for (int i = 0; i < 4; i++) begin
      op(8'h20);
      op(8'hFC | 8'(i));
      fin();
      if (i != 3) exp = 2'(i);
      chk(cfg.addr_mode, exp);
    end
  endtask
  task automatic t_win();
    op(8'h21);
    op(8'h05);
    #1;
    chk(busy, 1'b1);
    host.put(1'b1, 8'h99);
    op(8'h83);
    fin();
    chk(busy, 1'b0);
    chk({cfg.col_start, cfg.col_end}, 16'h0583);
    op(8'h22);
    op(8'hF9);
    op(8'h0E);
    fin();
    chk({cfg.page_start, cfg.page_end}, 6'h0E);
    op(8'h81);
    op(8'h00);
    op(8'h82);
    op(8'hFF);
    op(8'h07);
    fin();
    chk({cfg.contrast, cfg.brightness}, 16'h00FF);
    chk(cfg.col_lo, 4'h7);
  endtask
  task automatic t_lut_bank();
    five(8'h91, 8'hDF, 8'h20, 8'h21, 8'h3F);
    chk({cfg.pw_bank0, cfg.pw_a, cfg.pw_b, cfg.pw_c}, 24'h7E087F);
    chk(cfg.pw_d, 7'h40);
    op(8'h92);
    op(8'hE4);
    op(8'h1B);
    op(8'h00);
    #1;
    chk(cfg.bank_lo, 32'h0);
    op(8'hFF);
    fin();
    chk(cfg.bank_lo, 32'hFF001BE4);
    five(8'h93, 8'h1B, 8'hE4, 8'hFF, 8'h00);
    chk(cfg.bank_hi, 32'h00FFE41B);
    chk(cfg.bank_lo, 32'hFF001BE4);
  endtask
  initial begin
    err_total = 0;
    compares = 0;
    cycles = 0;
    resetn = 1'b0;
    repeat (10) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    #1;
    t_reset();
    t_single();
    t_mode();
    t_win();
    t_lut_bank();
    // reset again mid-run: everything back to defaults
    @(posedge sys_clk);
    resetn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    t_reset();
    // release again: first command after reset must still land
    @(posedge sys_clk);
    resetn <= 1'b1;
    op(8'h81);
    op(8'h3C);
    fin();
    chk(cfg.contrast, 8'h3C);
    chk(busy, 1'b0);
    results();
  end
endmodule
